// *** include/map_ctl_pkg.sv ***
/*
 * constants of the mode and memory-map control block: register indices,
 * field positions, reset values, region codes and timing counts.
 * assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package map_ctl_pkg;
    localparam int CLK_PERIOD_NS = 5;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_MODE = 6'h0b;
    localparam logic [5:0] IDX_RAM_POS = 6'h10;
    localparam logic [5:0] IDX_REG_POS = 6'h11;
    localparam logic [5:0] IDX_EE_POS = 6'h12;
    localparam logic [5:0] IDX_MAP_CTL = 6'h13;
    // mode register fields
    localparam int MB_SPECIAL_LOW = 7;
    localparam int MB_SEL_HIGH = 6;
    localparam int MB_SEL_LOW = 5;
    localparam int MB_STRETCH = 4;
    localparam int MB_VISIBLE = 3;
    localparam int MB_EXT_HALT = 2;
    localparam int MB_EMULATE = 0;
    // mapping register fields
    localparam int BASE_LSB = 3;
    localparam int EE_BASE_LSB = 4;
    localparam int MAP_HALT_BIT = 0;
    localparam int EE_READ_BIT = 0;
    localparam int NARROW_BIT = 6;
    localparam int FOLLOW_STR_LSB = 4;
    localparam int EXT_STR_LSB = 2;
    localparam int ROM_HALF_BIT = 1;
    localparam int ROM_EN_BIT = 0;
    // reset values, fixed addresses and mode codes
    localparam logic [4:0] REG_BASE_RST = 5'h00;
    localparam logic [4:0] RAM_BASE_RST = 5'h01;
    localparam logic [3:0] EE_BASE_RST = 4'h0;
    localparam logic [11:0] EE_START = 12'hd00;
    localparam logic [7:0] BDM_PAGE = 8'hff;
    localparam logic [1:0] AB_PERIPH = 2'h2;
    localparam logic [1:0] AB_NARROW = 2'h1;
    // region codes
    localparam logic [2:0] RG_NONE = 3'h0;
    localparam logic [2:0] RG_BDM = 3'h1;
    localparam logic [2:0] RG_REGS = 3'h2;
    localparam logic [2:0] RG_RAM = 3'h3;
    localparam logic [2:0] RG_EE = 3'h4;
    localparam logic [2:0] RG_ROM = 3'h5;
    localparam logic [2:0] RG_EXT = 3'h6;
    // wait-mode shutdown delay of the external bus, and bus response codes
    localparam int EBUS_DELAY_NS = 20;
    localparam logic [3:0] EBUS_DELAY_CYC = 4'((EBUS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : map_ctl_pkg

// *** logic/mode_map_ctl.sv ***
/*
 * mode latch, write protection and resource decode with an AXI4-Lite slave.
 * assumes mode pins and cpu_addr synchronous to aclk; master keeps one
 * write and one read in flight and offers address and data together.
 */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module mode_map_ctl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic background_pin,
    input wire logic mode_select_high,
    input wire logic mode_select_low,
    input wire logic wait_mode,
    input wire logic bdm_active,
    input wire logic [15:0] cpu_addr,
    output logic [2:0] operating_mode,
    output logic e_clock_stretch_enable,
    output logic [2:0] access_region,
    output logic access_narrow,
    output logic [1:0] access_stretch,
    output logic access_visible,
    output logic port_e_in_map,
    output logic ext_bus_halted,
    output logic map_iface_halted
);
    logic armed;
    logic special_mode_low_flag;
    logic [1:0] mode_ab;
    logic stretch_bit, internal_visibility_enable, ext_bus_wait_halt, port_e_emulate_flag;
    logic [4:0] register_block_base_bits, ram_base_bits;
    logic [3:0] eeprom_base_bits;
    logic map_iface_wait_halt, eeprom_read_enable, regfollow_narrow_bus;
    logic [1:0] follow_stretch, ext_stretch;
    logic rom_upper_half_select, program_rom_enable;
    logic special_wr, ab_wr, stretch_wr, vis_wr, emu_wr, rg_wr, rm_wr, ee_wr, ctl_wr;
    logic [3:0] ebus_cnt;
    logic wr_en;
    logic [5:0] widx;
    logic special;
    logic expanded;
    logic single;
    logic [7:0] wb;
    logic [1:0] next_ab;

    // normal: once; special: anytime
    function automatic logic wr_ok(input logic spec, input logic written);
        wr_ok = spec | ~written;
    endfunction : wr_ok

    // normal: once; special: all but the first
    function automatic logic wr_skip(input logic spec, input logic written);
        wr_skip = spec ? written : ~written;
    endfunction : wr_skip

    function automatic logic [7:0] read_reg(input logic [5:0] idx);
        read_reg = 8'h00;
        unique case (idx)
            map_ctl_pkg::IDX_MODE: read_reg = {special_mode_low_flag, mode_ab, stretch_bit | expanded,
                internal_visibility_enable, ext_bus_wait_halt, 1'b0, port_e_emulate_flag};
            map_ctl_pkg::IDX_REG_POS: read_reg = {register_block_base_bits, 2'h0, map_iface_wait_halt};
            map_ctl_pkg::IDX_RAM_POS: read_reg = {ram_base_bits, 3'h0};
            map_ctl_pkg::IDX_EE_POS: read_reg = {eeprom_base_bits, 3'h0, eeprom_read_enable | single};
            map_ctl_pkg::IDX_MAP_CTL: read_reg = {1'b0, regfollow_narrow_bus, follow_stretch, ext_stretch,
                rom_upper_half_select, program_rom_enable};
            default: read_reg = 8'h00;
        endcase
    endfunction : read_reg

    function automatic logic mapped(input logic [5:0] idx, input logic [1:0] ab);
        mapped = (idx == map_ctl_pkg::IDX_MODE && ab != map_ctl_pkg::AB_PERIPH)
            || idx == map_ctl_pkg::IDX_REG_POS || idx == map_ctl_pkg::IDX_RAM_POS
            || idx == map_ctl_pkg::IDX_EE_POS || idx == map_ctl_pkg::IDX_MAP_CTL;
    endfunction : mapped

    assign special = ~special_mode_low_flag;
    assign expanded = mode_ab[0];
    assign single = (mode_ab == 2'h0);
    assign widx = awaddr[7:2];
    assign wr_en = awready & awvalid & wvalid;
    assign wb = wdata[7:0];
    assign next_ab = {wb[map_ctl_pkg::MB_SEL_HIGH], wb[map_ctl_pkg::MB_SEL_LOW]};

    // write channel: both channels taken in one cycle, response follows
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            awready <= awvalid & wvalid & ~awready & ~bvalid;
            wready <= awvalid & wvalid & ~awready & ~bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= map_ctl_pkg::RESP_OKAY;
        end else if (wr_en) begin
            bvalid <= 1'b1;
            bresp <= mapped(widx, mode_ab) ? map_ctl_pkg::RESP_OKAY : map_ctl_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= map_ctl_pkg::RESP_OKAY;
        end else begin
            arready <= arvalid & ~arready & ~rvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= mapped(araddr[7:2], mode_ab) ? {24'h000000, read_reg(araddr[7:2])}
                    : 32'h0000_0000;
                rresp <= mapped(araddr[7:2], mode_ab) ? map_ctl_pkg::RESP_OKAY
                    : map_ctl_pkg::RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // mode register: pins caught in the first cycle after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed <= 1'b0;
            special_mode_low_flag <= 1'b0;
            mode_ab <= 2'h0;
            stretch_bit <= 1'b1;
            internal_visibility_enable <= 1'b1;
            ext_bus_wait_halt <= 1'b0;
            port_e_emulate_flag <= 1'b1;
            {special_wr, ab_wr, stretch_wr, vis_wr, emu_wr} <= 5'h00;
        end else if (!armed) begin
            armed <= 1'b1;
            // reserved code (normal peripheral) is forced to special peripheral mode
            special_mode_low_flag <= background_pin & ~(mode_select_high & ~mode_select_low);
            mode_ab <= {mode_select_high, mode_select_low};
            internal_visibility_enable <= ~background_pin | (mode_select_high & ~mode_select_low);
            port_e_emulate_flag <= ~background_pin | (mode_select_high & ~mode_select_low);
        end else if (wr_en && widx == map_ctl_pkg::IDX_MODE && wstrb[0]
                     && mode_ab != map_ctl_pkg::AB_PERIPH) begin
            if (special) begin
                special_wr <= 1'b1;
                if (special_wr) begin
                    special_mode_low_flag <= wb[map_ctl_pkg::MB_SPECIAL_LOW];
                end
            end
            ab_wr <= 1'b1;
            if (wr_ok(special, ab_wr) && next_ab != map_ctl_pkg::AB_PERIPH) begin
                mode_ab <= next_ab;
            end
            stretch_wr <= 1'b1;
            if (wr_ok(special, stretch_wr)) begin
                stretch_bit <= wb[map_ctl_pkg::MB_STRETCH];
            end
            vis_wr <= 1'b1;
            if (wr_skip(special, vis_wr)) begin
                internal_visibility_enable <= wb[map_ctl_pkg::MB_VISIBLE];
            end
            emu_wr <= 1'b1;
            if (wr_skip(special, emu_wr)) begin
                port_e_emulate_flag <= wb[map_ctl_pkg::MB_EMULATE];
            end
            if (!special) begin
                ext_bus_wait_halt <= wb[map_ctl_pkg::MB_EXT_HALT];
            end
        end
    end

    // mapping registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            register_block_base_bits <= map_ctl_pkg::REG_BASE_RST;
            ram_base_bits <= map_ctl_pkg::RAM_BASE_RST;
            eeprom_base_bits <= map_ctl_pkg::EE_BASE_RST;
            map_iface_wait_halt <= 1'b0;
            eeprom_read_enable <= 1'b1;
            regfollow_narrow_bus <= 1'b0;
            follow_stretch <= 2'h0;
            ext_stretch <= 2'h0;
            rom_upper_half_select <= 1'b0;
            program_rom_enable <= 1'b0;
            {rg_wr, rm_wr, ee_wr, ctl_wr} <= 4'h0;
        end else if (!armed) begin
            rom_upper_half_select <= ~mode_select_low;
            program_rom_enable <= ~mode_select_low;
        end else if (wr_en && wstrb[0]) begin
            if (widx == map_ctl_pkg::IDX_REG_POS) begin
                rg_wr <= 1'b1;
                if (wr_ok(special, rg_wr)) begin
                    register_block_base_bits <= wb[7:map_ctl_pkg::BASE_LSB];
                end
                if (!special) begin
                    map_iface_wait_halt <= wb[map_ctl_pkg::MAP_HALT_BIT];
                end
            end
            if (widx == map_ctl_pkg::IDX_RAM_POS) begin
                rm_wr <= 1'b1;
                if (wr_ok(special, rm_wr)) begin
                    ram_base_bits <= wb[7:map_ctl_pkg::BASE_LSB];
                end
            end
            if (widx == map_ctl_pkg::IDX_EE_POS) begin
                ee_wr <= 1'b1;
                if (wr_ok(special, ee_wr)) begin
                    eeprom_base_bits <= wb[7:map_ctl_pkg::EE_BASE_LSB];
                end
                if (!single) begin
                    eeprom_read_enable <= wb[map_ctl_pkg::EE_READ_BIT];
                end
            end
            if (widx == map_ctl_pkg::IDX_MAP_CTL) begin
                ctl_wr <= 1'b1;
                if (wr_ok(special, ctl_wr)) begin
                    regfollow_narrow_bus <= wb[map_ctl_pkg::NARROW_BIT];
                    follow_stretch <= wb[map_ctl_pkg::FOLLOW_STR_LSB +: 2];
                    ext_stretch <= wb[map_ctl_pkg::EXT_STR_LSB +: 2];
                    rom_upper_half_select <= wb[map_ctl_pkg::ROM_HALF_BIT];
                    program_rom_enable <= wb[map_ctl_pkg::ROM_EN_BIT];
                end
            end
        end
    end

    // address decode, registered so a mapping write acts one cycle later
    logic reg_hit, follow_hit, ram_hit, ee_hit, rom_hit, bdm_hit, vis_ok;
    assign reg_hit = cpu_addr[15:11] == register_block_base_bits && cpu_addr[10:9] == 2'h0;
    assign follow_hit = cpu_addr[15:11] == register_block_base_bits && cpu_addr[10:9] == 2'h1;
    assign ram_hit = cpu_addr[15:11] == ram_base_bits && !cpu_addr[10];
    assign ee_hit = (eeprom_read_enable | single) && cpu_addr[15:12] == eeprom_base_bits
        && cpu_addr[11:0] >= map_ctl_pkg::EE_START;
    assign rom_hit = program_rom_enable && cpu_addr[15] == rom_upper_half_select;
    assign bdm_hit = bdm_active && cpu_addr[15:8] == map_ctl_pkg::BDM_PAGE;
    assign vis_ok = internal_visibility_enable && expanded
        && !(special_mode_low_flag && mode_ab == map_ctl_pkg::AB_NARROW);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            access_region <= map_ctl_pkg::RG_NONE;
            access_narrow <= 1'b0;
            access_stretch <= 2'h0;
            access_visible <= 1'b0;
        end else begin
            if (bdm_hit) begin
                access_region <= map_ctl_pkg::RG_BDM;
            end else if (reg_hit) begin
                access_region <= map_ctl_pkg::RG_REGS;
            end else if (ram_hit) begin
                access_region <= map_ctl_pkg::RG_RAM;
            end else if (ee_hit) begin
                access_region <= map_ctl_pkg::RG_EE;
            end else if (rom_hit) begin
                access_region <= map_ctl_pkg::RG_ROM;
            end else begin
                access_region <= expanded ? map_ctl_pkg::RG_EXT : map_ctl_pkg::RG_NONE;
            end
            access_visible <= vis_ok && (bdm_hit || reg_hit || ram_hit || ee_hit || rom_hit);
            if (!expanded) begin
                access_narrow <= 1'b0;
                access_stretch <= 2'h0;
            end else if (bdm_hit || reg_hit || ram_hit || ee_hit || rom_hit) begin
                // visible internal cycles use the wide format
                access_narrow <= 1'b0;
                access_stretch <= 2'h0;
            end else if (follow_hit) begin
                access_narrow <= !mode_ab[1] || regfollow_narrow_bus;
                access_stretch <= follow_stretch;
            end else begin
                access_narrow <= !mode_ab[1];
                access_stretch <= ext_stretch;
            end
        end
    end

    // mode outputs, port E mapping and wait-mode shutdown
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            operating_mode <= 3'h0;
            e_clock_stretch_enable <= 1'b1;
            port_e_in_map <= 1'b1;
            map_iface_halted <= 1'b0;
            ext_bus_halted <= 1'b0;
            ebus_cnt <= 4'h0;
        end else begin
            operating_mode <= {special_mode_low_flag, mode_ab};
            e_clock_stretch_enable <= stretch_bit | expanded;
            port_e_in_map <= !(expanded && port_e_emulate_flag)
                && mode_ab != map_ctl_pkg::AB_PERIPH;
            map_iface_halted <= wait_mode && map_iface_wait_halt;
            if (wait_mode && ext_bus_wait_halt) begin
                if (ebus_cnt != map_ctl_pkg::EBUS_DELAY_CYC) begin
                    ebus_cnt <= ebus_cnt + 4'h1;
                end
            end else begin
                ebus_cnt <= 4'h0;
            end
            ext_bus_halted <= wait_mode && ext_bus_wait_halt
                && ebus_cnt == map_ctl_pkg::EBUS_DELAY_CYC;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rd_mode_periph;
        arvalid && arready && araddr[7:2] == map_ctl_pkg::IDX_MODE
            && mode_ab == map_ctl_pkg::AB_PERIPH;
    endsequence
    sequence s_wait_held;
        (wait_mode && ext_bus_wait_halt)[*6];
    endsequence

    AST_MODE_ABSENT: assert property (s_rd_mode_periph |=> rvalid && rresp == 2'h2)
        else $error("mode register answered in peripheral mode");
    AST_EXT_HALT: assert property (s_wait_held |-> ext_bus_halted)
        else $error("external bus not halted after wait delay");
    AST_EXT_RUN: assert property (!wait_mode |=> !ext_bus_halted)
        else $error("external bus halted outside wait");
    AST_SPECIAL_MODE_LOW_FLAG_NOFALL: assert property (armed && $past(armed) |-> !$fell(special_mode_low_flag))
        else $error("special mode flag cleared by software");
    AST_AB_LEGAL: assert property (armed && $past(armed) && $changed(mode_ab) |-> mode_ab != 2'h2)
        else $error("peripheral mode selected by write");
    AST_E_CLOCK_STRETCH_ENABLE_EXP: assert property (armed && expanded |=> e_clock_stretch_enable)
        else $error("stretch disabled in expanded mode");
    AST_NO_VIS_NN: assert property (special_mode_low_flag && mode_ab == 2'h1 |=> !access_visible)
        else $error("internal access visible in normal narrow mode");
    AST_MAP_HALT: assert property (wait_mode && map_iface_wait_halt |=> map_iface_halted)
        else $error("mapping interface kept running in wait");
    AST_REG_PRIO: assert property (reg_hit && !bdm_active |=> access_region == 3'h2)
        else $error("register block lost decode priority");
endmodule : mode_map_ctl
`default_nettype wire

// *** bench/cpu_side_model.sv ***
/*
 cpu side of the decoder: presents one address per cycle, registered.
 assumes the bench requests a new address just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] next_addr,
    output logic [15:0] cpu_addr
);
    // address is launched from a flop, as the core's address bus is
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_addr <= 16'h0000;
        end else begin
            cpu_addr <= next_addr;
        end
    end
endmodule : cpu_side_model
`default_nettype wire

// *** bench/test_mode_map_ctl.sv ***
/*
 self-checking bench of mode_map_ctl: register access over AXI4-Lite,
 decode table, wait-mode halts. assumes map_ctl_pkg is compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_mode_map_ctl;
    typedef struct {
        logic [15:0] addr;
        logic bdm;
        logic [2:0] region;
        logic narrow;
        logic [1:0] stretch;
    } row_t;
    logic aclk = 1'b0, aresetn = 1'b0, wait_mode = 1'b0, bdm_active = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic background_pin = 1'b0, mode_select_high = 1'b0, mode_select_low = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic [15:0] next_addr = 16'h0, cpu_addr;
    logic awready, wready, bvalid, arready, rvalid, e_clock_stretch_enable;
    logic access_narrow, access_visible, port_e_in_map, ext_bus_halted, map_iface_halted;
    logic [1:0] bresp, rresp, access_stretch, rs;
    logic [2:0] operating_mode, access_region;
    int num_errors = 0, total_checks = 0;
    row_t rows [8] = '{
        '{16'h0800, 1'b0, map_ctl_pkg::RG_REGS, 1'b0, 2'h0},
        '{16'h0a00, 1'b0, map_ctl_pkg::RG_EXT, 1'b1, 2'h3},
        '{16'h8000, 1'b0, map_ctl_pkg::RG_RAM, 1'b0, 2'h0},
        '{16'h8400, 1'b0, map_ctl_pkg::RG_ROM, 1'b0, 2'h0},
        '{16'h0d00, 1'b0, map_ctl_pkg::RG_EE, 1'b0, 2'h0},
        '{16'h4000, 1'b0, map_ctl_pkg::RG_EXT, 1'b0, 2'h1},
        '{16'hff10, 1'b1, map_ctl_pkg::RG_BDM, 1'b0, 2'h0},
        '{16'h0000, 1'b0, map_ctl_pkg::RG_EXT, 1'b0, 2'h1}};
    logic [5:0] ridx [5] = '{map_ctl_pkg::IDX_MODE, map_ctl_pkg::IDX_RAM_POS,
        map_ctl_pkg::IDX_REG_POS, map_ctl_pkg::IDX_EE_POS, map_ctl_pkg::IDX_MAP_CTL};
    logic [7:0] rexp [5] = '{8'hf0, 8'h08, 8'h00, 8'h01, 8'h00};

    mode_map_ctl dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
        .rready, .rdata, .rresp, .background_pin, .mode_select_high, .mode_select_low,
        .wait_mode, .bdm_active, .cpu_addr, .operating_mode, .e_clock_stretch_enable,
        .access_region, .access_narrow, .access_stretch, .access_visible, .port_e_in_map,
        .ext_bus_halted, .map_iface_halted);
    cpu_side_model cpu (.aclk, .aresetn, .next_addr, .cpu_addr);

    always #2.5 aclk = ~aclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_done = 1;
            end
            if (wready === 1'b1) begin
                wvalid <= 1'b0;
                w_done = 1;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        rs = bresp;
    endtask : wr

    task automatic rdreg(input logic [5:0] idx);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask : rdreg

    task automatic rchk(input string n, input logic [5:0] idx, input logic [7:0] e);
        rdreg(idx);
        chk(n, {24'h0, e}, rd);
    endtask : rchk

    // address reaches the decoder one edge after the request, answer one edge later
    task automatic dec(input row_t r);
        @(posedge aclk);
        next_addr <= r.addr;
        bdm_active <= r.bdm;
        repeat (3) @(posedge aclk);
        #1;
        chk("region", 32'(r.region), 32'(access_region));
        chk("narrow", 32'(r.narrow), 32'(access_narrow));
        chk("stretch", 32'(r.stretch), 32'(access_stretch));
    endtask : dec

    task automatic do_reset(input logic [2:0] pins);
        @(posedge aclk);
        aresetn <= 1'b0;
        {background_pin, mode_select_high, mode_select_low} <= pins;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask : do_reset

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end

    initial begin
        do_reset(3'b111);
        wr(map_ctl_pkg::IDX_REG_POS, 8'h08);
        chk("bresp okay", 32'(map_ctl_pkg::RESP_OKAY), 32'(rs));
        wr(map_ctl_pkg::IDX_REG_POS, 8'h10);
        wr(map_ctl_pkg::IDX_RAM_POS, 8'h80);
        wr(map_ctl_pkg::IDX_RAM_POS, 8'h10);
        wr(map_ctl_pkg::IDX_MAP_CTL, 8'h77);
        wr(map_ctl_pkg::IDX_MAP_CTL, 8'h00);
        wr(map_ctl_pkg::IDX_REG_POS, 8'h01);
        foreach (rows[i]) dec(rows[i]);
        rchk("reg pos", map_ctl_pkg::IDX_REG_POS, 8'h09);
        rchk("ram pos", map_ctl_pkg::IDX_RAM_POS, 8'h80);
        rchk("map ctl", map_ctl_pkg::IDX_MAP_CTL, 8'h77);
        wr(map_ctl_pkg::IDX_MODE, 8'hf6);
        rchk("mode", map_ctl_pkg::IDX_MODE, 8'hf4);
        wait_mode <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk("ebus early", 32'h0, 32'(ext_bus_halted));
        repeat (8) @(posedge aclk);
        #1;
        chk("ebus halt", 32'h1, 32'(ext_bus_halted));
        chk("map halt", 32'h1, 32'(map_iface_halted));
        @(posedge aclk);
        wait_mode <= 1'b0;
        repeat (8) @(posedge aclk);
        #1;
        chk("map run", 32'h0, 32'(map_iface_halted));
        rdreg(6'h3f);
        chk("unmapped resp", 32'(map_ctl_pkg::RESP_SLVERR), 32'(rs));
        chk("unmapped data", 32'h0, rd);
        wr(6'h3f, 8'h00);
        chk("unmapped bresp", 32'(map_ctl_pkg::RESP_SLVERR), 32'(rs));
        do_reset(3'b111);
        foreach (ridx[i]) rchk("reset", ridx[i], rexp[i]);
        chk("opmode", 32'h7, 32'(operating_mode));
        chk("port e map", 32'h1, 32'(port_e_in_map));
        do_reset(3'b000);
        rchk("mode ssc", map_ctl_pkg::IDX_MODE, 8'h19);
        chk("port e map ssc", 32'h1, 32'(port_e_in_map));
        wr(map_ctl_pkg::IDX_MODE, 8'h44);
        rchk("mode w1", map_ctl_pkg::IDX_MODE, 8'h09);
        chk("e_clock_stretch_enable ssc", 32'h0, 32'(e_clock_stretch_enable));
        wr(map_ctl_pkg::IDX_MODE, 8'h21);
        rchk("mode w2", map_ctl_pkg::IDX_MODE, 8'h31);
        chk("opmode sen", 32'h1, 32'(operating_mode));
        chk("port e emu", 32'h0, 32'(port_e_in_map));
        chk("e_clock_stretch_enable sen", 32'h1, 32'(e_clock_stretch_enable));
        wr(map_ctl_pkg::IDX_MODE, 8'h29);
        dec('{16'h0000, 1'b0, map_ctl_pkg::RG_REGS, 1'b0, 2'h0});
        chk("visible", 32'h1, 32'(access_visible));
        wr(map_ctl_pkg::IDX_REG_POS, 8'h08);
        wr(map_ctl_pkg::IDX_REG_POS, 8'h10);
        rchk("reg pos spc", map_ctl_pkg::IDX_REG_POS, 8'h10);
        do_reset(3'b101);
        wr(map_ctl_pkg::IDX_MODE, 8'hb9);
        dec('{16'h0000, 1'b0, map_ctl_pkg::RG_REGS, 1'b0, 2'h0});
        chk("visible nn", 32'h0, 32'(access_visible));
        do_reset(3'b010);
        rdreg(map_ctl_pkg::IDX_MODE);
        chk("mode periph", 32'(map_ctl_pkg::RESP_SLVERR), 32'(rs));
        wr(map_ctl_pkg::IDX_MODE, 8'h00);
        chk("mode periph wr", 32'(map_ctl_pkg::RESP_SLVERR), 32'(rs));
        wrap_up();
    end
endmodule : test_mode_map_ctl
`default_nettype wire
